// [src/rtw_pkg.sv]
// Package with register map, field layout and constants of the reload and wake-up timers.
package rtw_pkg;
	// Register offsets.
	localparam logic [7:0] ADDR_T3_CONFIG = 8'h1e;
	localparam logic [7:0] ADDR_T3_RELOAD_HIGH = 8'h1f;
	localparam logic [7:0] ADDR_T3_RELOAD_LOW = 8'h20;
	localparam logic [7:0] ADDR_T3_COUNT_HIGH = 8'h21;
	localparam logic [7:0] ADDR_T3_COUNT_LOW = 8'h22;
	localparam logic [7:0] ADDR_WAKE_CONTROL = 8'h23;
	localparam logic [7:0] ADDR_WAKE_RELOAD_HIGH = 8'h24;
	localparam logic [7:0] ADDR_WAKE_RELOAD_LOW = 8'h25;
	localparam logic [7:0] ADDR_WAKE_COUNT_HIGH = 8'h26;
	localparam logic [7:0] ADDR_WAKE_COUNT_LOW = 8'h27;
	localparam logic [7:0] ADDR_DETECT_CONFIG = 8'h30;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h31;
	// Wake-up timer control fields.
	localparam int CTL_ACTIVE = 7;
	localparam int CTL_RUN_CHANGE = 6;
	localparam int CTL_AUTO_TRIM = 5;
	localparam int CTL_AUTO_DETECT = 4;
	localparam int CTL_AUTO_RELOAD = 3;
	localparam int CTL_AUTO_WAKE = 2;
	localparam int CTL_CLK_MSB = 1;
	// Timer3 configuration fields.
	localparam int T3_MODE_MSB = 5;
	localparam int T3_MODE_LSB = 4;
	localparam logic [1:0] T3_MODE_AFTER_TX = 2'h1;
	// Detection configuration and status fields.
	localparam int DET_STAY_ACTIVE = 0;
	localparam int DET_POWER_DOWN = 1;
	localparam int STAT_WAKE_IRQ = 0;
	localparam int STAT_CARD_IRQ = 1;
	// Clock divider selections for the wake-up timer.
	localparam logic [1:0] CLK_DIV1 = 2'h0;
	localparam logic [1:0] CLK_DIV8 = 2'h1;
	localparam logic [1:0] CLK_DIV16 = 2'h2;
	localparam logic [4:0] DIV8_MASK = 5'h07;
	localparam logic [4:0] DIV16_MASK = 5'h0f;
	localparam logic [4:0] DIV32_MASK = 5'h1f;
	// Reset values.
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// Register bus request.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtw_bus_req_t;
	// Detection sequence states, Gray coded.
	typedef enum logic [1:0] {
		DET_IDLE = 2'b00,
		DET_FIELD = 2'b01,
		DET_DECIDE = 2'b11
	} rtw_det_state_t;
endpackage

// [src/rtw_timers.sv]
// Reload timer three and wake-up timer four with their register port.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Timer3 reload is two bytes, copied into the counter at each start event.
// - Reload writes leave a running count alone until the next start.
// - Timer3 live count reads back as two read-only bytes.
// - Wake-up timer wakes system after its interval and can launch detection.
// - Control bit 7 shows whether the wake-up timer counts.
// - Bit 7 changes on write only with bit 6 set; that starts or stops.
// - Bit 5 starts oscillator trimming at each wake-up underflow.
// - Bit 4 launches a card detection sequence at each underflow.
// - Card found raises interrupt and stays active when configured.
// - No card found enters power-down when enabled and bit 2 is set.
// - During auto detection the wake-up timer reloads with no gap.
// - Timer3 sets how long the RF field is on during detection.
// - Bit 3 set reloads after zero; with bits 3 and 4 both clear it counts to zero and stops.
// - Wake-up underflow sets the wake-up interrupt flag.
// - Bit 2 set wakes the device at wake-up underflow.
// - Bits 1..0 pick oscillator clock undivided, /8, /16 or /32.
// - Start mode 01 starts timer3 at end of transmission.
// - Wake-up reload is two bytes loaded at a start event and at underflow with bit 3 or 4 set.
module rtw_timers (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire rtw_pkg::rtw_bus_req_t bus_req_in,
	output logic [7:0] rdata_out,
	input wire logic low_freq_osc_in,
	input wire logic tx_end_in,
	input wire logic card_present_in,
	output logic rf_field_on_out,
	output logic trim_start_out,
	output logic wake_out,
	output logic power_down_out,
	output logic card_irq_out
);
	import rtw_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers.
	logic [1:0] rst_sync;
	logic rst_n;
	logic lfo_meta;
	logic lfo_sync;
	logic lfo_prev;
	logic card_meta;
	logic card_sync;

	// Reset is asserted at once and released after two clock edges.
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Oscillator and card detect levels come from outside this clock.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			lfo_meta <= 1'b0;
			lfo_sync <= 1'b0;
			lfo_prev <= 1'b0;
			card_meta <= 1'b0;
			card_sync <= 1'b0;
		end else begin
			lfo_meta <= low_freq_osc_in;
			lfo_sync <= lfo_meta;
			lfo_prev <= lfo_sync;
			card_meta <= card_present_in;
			card_sync <= card_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.
	logic [7:0] t3_reload_high;
	logic [7:0] t3_reload_low;
	logic [1:0] t3_mode;
	logic [15:0] t3_count;
	logic t3_running;
	logic [7:0] wake_reload_high;
	logic [7:0] wake_reload_low;
	logic [15:0] wake_count;
	logic wake_active;
	logic [5:0] wake_ctl;
	logic [1:0] det_cfg;
	logic wake_irq_flag;
	logic card_irq_flag;
	logic [4:0] prescale;
	rtw_det_state_t det_state;
	rtw_det_state_t next_det_state;
	logic wr_ctl;
	logic lfo_edge;
	logic wake_tick;
	logic wake_under;
	logic t3_under;
	logic t3_start;
	logic det_launch;
	logic card_found;
	logic no_card;

	// Writes to the control word, oscillator edges and underflows.
	assign wr_ctl = bus_req_in.wr && (bus_req_in.addr == ADDR_WAKE_CONTROL);
	assign lfo_edge = lfo_sync && !lfo_prev;
	assign wake_tick = lfo_edge && div_hit(wake_ctl[CTL_CLK_MSB:0], prescale);
	assign wake_under = wake_active && wake_tick && (wake_count == RESET_WORD);
	assign t3_under = t3_running && (t3_count == RESET_WORD);
	assign det_launch = wake_under && wake_ctl[CTL_AUTO_DETECT];
	assign t3_start = det_launch || (tx_end_in && (t3_mode == T3_MODE_AFTER_TX));
	assign card_found = (det_state == DET_DECIDE) && card_sync;
	assign no_card = (det_state == DET_DECIDE) && !card_sync;

	// Tick decision from the oscillator prescaler and the clock selection.
	function automatic logic div_hit(input logic [1:0] sel, input logic [4:0] pre);
		logic [4:0] mask;
		mask = (sel == CLK_DIV8) ? DIV8_MASK : (sel == CLK_DIV16) ? DIV16_MASK : DIV32_MASK;
		div_hit = (sel == CLK_DIV1) || ((pre & mask) == mask);
	endfunction

	// Software-written configuration; reserved bits are never stored.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			t3_reload_high <= RESET_BYTE;
			t3_reload_low <= RESET_BYTE;
			t3_mode <= 2'h0;
			wake_reload_high <= RESET_BYTE;
			wake_reload_low <= RESET_BYTE;
			wake_ctl <= 6'h00;
			det_cfg <= 2'h0;
		end else if (bus_req_in.wr) begin
			unique case (bus_req_in.addr)
				ADDR_T3_RELOAD_HIGH: t3_reload_high <= bus_req_in.wdata;
				ADDR_T3_RELOAD_LOW: t3_reload_low <= bus_req_in.wdata;
				ADDR_T3_CONFIG: t3_mode <= bus_req_in.wdata[T3_MODE_MSB:T3_MODE_LSB];
				ADDR_WAKE_RELOAD_HIGH: wake_reload_high <= bus_req_in.wdata;
				ADDR_WAKE_RELOAD_LOW: wake_reload_low <= bus_req_in.wdata;
				ADDR_WAKE_CONTROL: wake_ctl <= bus_req_in.wdata[5:0];
				ADDR_DETECT_CONFIG: det_cfg <= bus_req_in.wdata[1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wake-up timer.

	// Prescaler counts oscillator edges for the divided clocks.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= 5'h00;
		end else if (wr_ctl && bus_req_in.wdata[CTL_RUN_CHANGE]) begin
			prescale <= 5'h00;
		end else if (lfo_edge) begin
			prescale <= prescale + 5'h01;
		end
	end

	// Run state: a run-change write wins over an underflow stop.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			wake_active <= 1'b0;
		end else if (wr_ctl && bus_req_in.wdata[CTL_RUN_CHANGE]) begin
			wake_active <= bus_req_in.wdata[CTL_ACTIVE];
		end else if (wake_under && !wake_ctl[CTL_AUTO_RELOAD] && !wake_ctl[CTL_AUTO_DETECT]) begin
			wake_active <= 1'b0;
		end
	end

	// Counter: loaded at start, reloaded after underflow when restarting.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			wake_count <= RESET_WORD;
		end else if (wr_ctl && bus_req_in.wdata[CTL_RUN_CHANGE] && bus_req_in.wdata[CTL_ACTIVE]) begin
			wake_count <= {wake_reload_high, wake_reload_low};
		end else if (wake_under) begin
			if (wake_ctl[CTL_AUTO_RELOAD] || wake_ctl[CTL_AUTO_DETECT]) begin
				wake_count <= {wake_reload_high, wake_reload_low};
			end
		end else if (wake_active && wake_tick) begin
			wake_count <= wake_count - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timer3, running on the system clock.

	// Start loads the reload word; underflow stops the count.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			t3_count <= RESET_WORD;
			t3_running <= 1'b0;
		end else if (t3_start) begin
			t3_count <= {t3_reload_high, t3_reload_low};
			t3_running <= 1'b1;
		end else if (t3_under) begin
			t3_running <= 1'b0;
		end else if (t3_running) begin
			t3_count <= t3_count - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Card detection sequence.

	// Field stays on while timer3 runs, then the result is judged.
	always_comb begin
		next_det_state = det_state;
		unique case (det_state)
			DET_IDLE: if (det_launch) next_det_state = DET_FIELD;
			DET_FIELD: if (t3_under) next_det_state = DET_DECIDE;
			DET_DECIDE: next_det_state = DET_IDLE;
			default: next_det_state = DET_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			det_state <= DET_IDLE;
		end else begin
			det_state <= next_det_state;
		end
	end

	// Field output follows the detection phase.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			rf_field_on_out <= 1'b0;
		end else begin
			rf_field_on_out <= (next_det_state == DET_FIELD);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// System events.

	// One-cycle pulses for trimming, wake and card interrupt.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			trim_start_out <= 1'b0;
			wake_out <= 1'b0;
			card_irq_out <= 1'b0;
		end else begin
			trim_start_out <= wake_under && wake_ctl[CTL_AUTO_TRIM];
			wake_out <= wake_under && wake_ctl[CTL_AUTO_WAKE];
			card_irq_out <= card_found;
		end
	end

	// Power-down: entered on no card, left on wake or card found when kept.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			power_down_out <= 1'b0;
		end else if (wake_under && wake_ctl[CTL_AUTO_WAKE]) begin
			power_down_out <= 1'b0;
		end else if (card_found && det_cfg[DET_STAY_ACTIVE]) begin
			power_down_out <= 1'b0;
		end else if (no_card && det_cfg[DET_POWER_DOWN] && wake_ctl[CTL_AUTO_WAKE]) begin
			power_down_out <= 1'b1;
		end
	end

	// Sticky flags: a write of one clears, a new event in the same cycle wins.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			wake_irq_flag <= 1'b0;
			card_irq_flag <= 1'b0;
		end else begin
			if (wake_under) begin
				wake_irq_flag <= 1'b1;
			end else if (bus_req_in.wr && bus_req_in.addr == ADDR_EVENT_STATUS &&
				bus_req_in.wdata[STAT_WAKE_IRQ]) begin
				wake_irq_flag <= 1'b0;
			end
			if (card_found) begin
				card_irq_flag <= 1'b1;
			end else if (bus_req_in.wr && bus_req_in.addr == ADDR_EVENT_STATUS &&
				bus_req_in.wdata[STAT_CARD_IRQ]) begin
				card_irq_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port: data stand only in the cycle after the strobe.
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= RESET_BYTE;
		end else if (bus_req_in.rd) begin
			unique case (bus_req_in.addr)
				ADDR_T3_CONFIG: rdata_out <= {2'h0, t3_mode, 4'h0};
				ADDR_T3_RELOAD_HIGH: rdata_out <= t3_reload_high;
				ADDR_T3_RELOAD_LOW: rdata_out <= t3_reload_low;
				ADDR_T3_COUNT_HIGH: rdata_out <= t3_count[15:8];
				ADDR_T3_COUNT_LOW: rdata_out <= t3_count[7:0];
				ADDR_WAKE_CONTROL: rdata_out <= {wake_active, 1'b0, wake_ctl};
				ADDR_WAKE_RELOAD_HIGH: rdata_out <= wake_reload_high;
				ADDR_WAKE_RELOAD_LOW: rdata_out <= wake_reload_low;
				ADDR_WAKE_COUNT_HIGH: rdata_out <= wake_count[15:8];
				ADDR_WAKE_COUNT_LOW: rdata_out <= wake_count[7:0];
				ADDR_DETECT_CONFIG: rdata_out <= {6'h00, det_cfg};
				ADDR_EVENT_STATUS: rdata_out <= {6'h00, card_irq_flag, wake_irq_flag};
				default: rdata_out <= RESET_BYTE;
			endcase
		end else begin
			rdata_out <= RESET_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n);

	a_t3_load_reload:
		assert property (t3_start |=> t3_count == $past({t3_reload_high, t3_reload_low}))
		else $error("timer3 did not load its reload word");
	a_t3_reload_quiet:
		assert property (t3_running && !t3_start && !t3_under && bus_req_in.wr &&
			(bus_req_in.addr == ADDR_T3_RELOAD_HIGH || bus_req_in.addr == ADDR_T3_RELOAD_LOW) |=>
			t3_count == $past(t3_count) - 16'h0001)
		else $error("timer3 reload write disturbed the count");
	a_t3_count_read:
		assert property (bus_req_in.rd && bus_req_in.addr == ADDR_T3_COUNT_LOW |=>
			rdata_out == $past(t3_count[7:0]))
		else $error("timer3 low count read wrong");
	a_active_read:
		assert property (bus_req_in.rd && bus_req_in.addr == ADDR_WAKE_CONTROL |=>
			rdata_out[7] == $past(wake_active) && !rdata_out[6])
		else $error("control read does not show run state");
	a_run_change_gate:
		assert property (wr_ctl && !bus_req_in.wdata[CTL_RUN_CHANGE] && !wake_under |=>
			$stable(wake_active))
		else $error("run state changed without run-change bit");
	a_trim_pulse:
		assert property (wake_under && wake_ctl[CTL_AUTO_TRIM] |=> trim_start_out)
		else $error("trim not started on underflow");
	a_detect_launch:
		assert property (det_launch && det_state == DET_IDLE |=> rf_field_on_out && t3_running)
		else $error("detection did not turn on the field");
	a_card_irq:
		assert property (card_found |=> card_irq_out && card_irq_flag)
		else $error("card found without interrupt");
	a_no_card_down:
		assert property (no_card && det_cfg[DET_POWER_DOWN] && wake_ctl[CTL_AUTO_WAKE] &&
			!wake_under |=> power_down_out)
		else $error("no card did not enter power-down");
	a_no_gap_reload:
		assert property (wake_under && wake_ctl[CTL_AUTO_RELOAD] && !wr_ctl |=>
			wake_active && wake_count == $past({wake_reload_high, wake_reload_low}))
		else $error("wake-up timer did not reload");
	a_one_shot_stop:
		assert property (wake_under && !wake_ctl[CTL_AUTO_RELOAD] && !wake_ctl[CTL_AUTO_DETECT] &&
			!wr_ctl |=> !wake_active)
		else $error("one-shot wake-up timer kept running");
	a_wake_flag:
		assert property (wake_under |=> wake_irq_flag)
		else $error("underflow did not set wake flag");
	a_auto_wake:
		assert property (wake_under && wake_ctl[CTL_AUTO_WAKE] |=> wake_out && !power_down_out)
		else $error("auto wake missing");
	a_div_tick:
		assert property (wake_active && lfo_edge && wake_ctl[1:0] == CLK_DIV1 && wake_count != 0 &&
			!wr_ctl |=> wake_count == $past(wake_count) - 16'h0001)
		else $error("undivided tick did not decrement");
	a_tx_start:
		assert property (tx_end_in && t3_mode == T3_MODE_AFTER_TX |=> t3_running)
		else $error("timer3 not started after transmission");
	a_read_once:
		assert property (!bus_req_in.rd |=> rdata_out == RESET_BYTE)
		else $error("read data stood without a read");

	c_detect_found: cover property (det_launch ##[1:300] card_found);
	c_detect_empty: cover property (no_card ##1 power_down_out);
	c_wake_restart: cover property (wake_under && wake_ctl[CTL_AUTO_RELOAD]);
	c_trim: cover property (trim_start_out);
endmodule
`default_nettype wire

// [verification/rtw_timers_tb.sv]
// Self-checking testbench for the reload timer and the wake-up timer.
`timescale 1ns/1ns
`default_nettype none
module rtw_timers_tb;
	import rtw_pkg::*;
	logic clock_in;
	logic arst_n;
	rtw_bus_req_t bus_req;
	logic [7:0] rdata;
	logic low_freq_osc;
	logic tx_end;
	logic card;
	logic rf_on;
	logic trim;
	logic wake;
	logic pdown;
	logic cirq;
	int mismatches;
	int checked;
	int wake_n;
	int trim_n;
	int rf_n;
	int cirq_n;
	int base_w;
	int base_t;
	int base_r;
	int div;
	logic [7:0] lo_a;
	logic [7:0] lo_b;

	////////////////////////////////////////////////////////////////////////////////
	// Design under test.
	rtw_timers u_rtw_timers (
		.clock_in(clock_in),
		.arst_n_in(arst_n),
		.bus_req_in(bus_req),
		.rdata_out(rdata),
		.low_freq_osc_in(low_freq_osc),
		.tx_end_in(tx_end),
		.card_present_in(card),
		.rf_field_on_out(rf_on),
		.trim_start_out(trim),
		.wake_out(wake),
		.power_down_out(pdown),
		.card_irq_out(cirq)
	);

	// The clock runs at 25 MHz.
	always #20 clock_in = ~clock_in;

	// Pulse and level counters of the outputs, compared as differences except cirq_n.
	always @(posedge clock_in) begin
		if (wake === 1'b1) wake_n <= wake_n + 1;
		if (trim === 1'b1) trim_n <= trim_n + 1;
		if (rf_on === 1'b1) rf_n <= rf_n + 1;
		if (cirq === 1'b1) cirq_n <= cirq_n + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("Checks made: %0d, mismatches: %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Compares two values and reports a difference.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// One write cycle; entered and left just after a rising edge.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		bus_req <= {1'b0, 1'b1, a, d};
		@(posedge clock_in);
		bus_req <= '0;
		@(posedge clock_in);
	endtask

	// One read cycle; the data are taken in the single cycle after the strobe.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus_req <= {1'b1, 1'b0, a, 8'h00};
		@(posedge clock_in);
		bus_req <= '0;
		@(negedge clock_in);
		check(rdata, exp);
		@(posedge clock_in);
	endtask

	// n oscillator periods of eight clocks each, long enough to pass the input synchroniser.
	task automatic lfo_tick(input int n);
		repeat (n) begin
			low_freq_osc <= 1'b1;
			repeat (4) @(posedge clock_in);
			low_freq_osc <= 1'b0;
			repeat (4) @(posedge clock_in);
		end
	endtask

	// Bounded wait for the power-down level; a missing level ends the run.
	task automatic wait_pd(input logic lvl);
		int i;
		for (i = 0; i < 60 && pdown !== lvl; i++) @(posedge clock_in);
		if (pdown !== lvl) begin
			mismatches++;
			$display("ERROR at %0t: power-down level not reached", $time);
			wrap_up();
		end
	endtask

	// Watchdog against a hang.
	initial begin
		repeat (30000) @(posedge clock_in);
		mismatches++;
		$display("ERROR at %0t: run did not finish", $time);
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		clock_in = 1'b0;
		arst_n = 1'b0;
		bus_req = '0;
		low_freq_osc = 1'b0;
		tx_end = 1'b0;
		card = 1'b0;
		mismatches = 0;
		checked = 0;
		wake_n = 0;
		trim_n = 0;
		rf_n = 0;
		cirq_n = 0;
		repeat (4) @(posedge clock_in);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock_in);
		// Reset state and unmapped places.
		rd_chk(ADDR_WAKE_CONTROL, 8'h00);
		rd_chk(8'h40, 8'h00);
		// Timer3 starts at end of transmission from both reload bytes.
		wr_reg(ADDR_T3_RELOAD_HIGH, 8'h12);
		wr_reg(ADDR_T3_RELOAD_LOW, 8'h34);
		rd_chk(ADDR_T3_RELOAD_HIGH, 8'h12);
		rd_chk(ADDR_T3_RELOAD_LOW, 8'h34);
		wr_reg(ADDR_T3_CONFIG, 8'h10);
		tx_end <= 1'b1;
		@(posedge clock_in);
		tx_end <= 1'b0;
		@(posedge clock_in);
		// No card reception is modelled, so the live count may be read at any time.
		rd_chk(ADDR_T3_COUNT_HIGH, 8'h12);
		wr_reg(ADDR_T3_RELOAD_HIGH, 8'h56);
		wr_reg(ADDR_T3_COUNT_HIGH, 8'hff);
		rd_chk(ADDR_T3_COUNT_HIGH, 8'h12);
		// Back-to-back reads of the low count byte see one decrement.
		bus_req <= {1'b1, 1'b0, ADDR_T3_COUNT_LOW, 8'h00};
		@(posedge clock_in);
		@(negedge clock_in);
		lo_a = rdata;
		@(posedge clock_in);
		bus_req <= '0;
		@(negedge clock_in);
		lo_b = rdata;
		@(posedge clock_in);
		check(lo_a - lo_b, 8'h01);
		tx_end <= 1'b1;
		@(posedge clock_in);
		tx_end <= 1'b0;
		@(posedge clock_in);
		rd_chk(ADDR_T3_COUNT_HIGH, 8'h56);
		// Clock selection: count holds for div-1 ticks, drops on the next.
		wr_reg(ADDR_WAKE_RELOAD_HIGH, 8'h00);
		wr_reg(ADDR_WAKE_RELOAD_LOW, 8'h02);
		for (int sel = 0; sel < 4; sel++) begin
			div = (sel == 0) ? 1 : (4 << sel);
			wr_reg(ADDR_WAKE_CONTROL, 8'hc0 | 8'(sel));
			lfo_tick(div - 1);
			rd_chk(ADDR_WAKE_COUNT_LOW, 8'h02);
			lfo_tick(1);
			rd_chk(ADDR_WAKE_COUNT_LOW, 8'h01);
		end
		// One-shot run stops at underflow and sets the flag, no wake pulse.
		base_w = wake_n;
		wr_reg(ADDR_WAKE_CONTROL, 8'hc0);
		rd_chk(ADDR_WAKE_CONTROL, 8'h80);
		lfo_tick(3);
		rd_chk(ADDR_WAKE_CONTROL, 8'h00);
		rd_chk(ADDR_EVENT_STATUS, 8'h01);
		check(wake_n - base_w, 0);
		wr_reg(ADDR_EVENT_STATUS, 8'h01);
		rd_chk(ADDR_EVENT_STATUS, 8'h00);
		// Auto reload with auto wake and trimming: two underflows.
		base_t = trim_n;
		// Trimming runs without detection, so timer3 stays free for a trim timer.
		wr_reg(ADDR_WAKE_CONTROL, 8'hec);
		lfo_tick(6);
		check(wake_n - base_w, 2);
		check(trim_n - base_t, 2);
		rd_chk(ADDR_WAKE_CONTROL, 8'hac);
		wr_reg(ADDR_WAKE_CONTROL, 8'h2c);
		rd_chk(ADDR_WAKE_CONTROL, 8'hac);
		wr_reg(ADDR_WAKE_CONTROL, 8'h40);
		rd_chk(ADDR_WAKE_CONTROL, 8'h00);
		// Card detection with no card: field time from timer3, then power-down.
		wr_reg(ADDR_T3_RELOAD_HIGH, 8'h00);
		wr_reg(ADDR_T3_RELOAD_LOW, 8'h05);
		wr_reg(ADDR_WAKE_RELOAD_LOW, 8'h00);
		wr_reg(ADDR_DETECT_CONFIG, 8'h03);
		wr_reg(ADDR_EVENT_STATUS, 8'h03);
		base_r = rf_n;
		wr_reg(ADDR_WAKE_CONTROL, 8'hd4);
		lfo_tick(1);
		wait_pd(1'b1);
		check(rf_n - base_r, 6);
		rd_chk(ADDR_WAKE_CONTROL, 8'h94);
		// Card present: interrupt pulse and flag; auto wake is dropped first, so only a found card
		// can take the device out of power-down.
		wr_reg(ADDR_WAKE_CONTROL, 8'h10);
		rd_chk(ADDR_WAKE_CONTROL, 8'h90);
		card <= 1'b1;
		lfo_tick(1);
		wait_pd(1'b0);
		repeat (12) @(posedge clock_in);
		check(cirq_n, 1);
		check(pdown, 1'b0);
		rd_chk(ADDR_EVENT_STATUS, 8'h03);
		wr_reg(ADDR_WAKE_CONTROL, 8'h40);
		wrap_up();
	end
endmodule
`default_nettype wire
